//--- core/sarf_pkg.sv
// shared constants and types for the serial converter readout frame
package sarf_pkg;
   // ==========================================================
   // frame layout
   localparam int CODE_BITS = 8;
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] LEAD_ZEROS = 5'h03;
   localparam logic [4:0] TRAIL_ZEROS = 5'h04;
   localparam logic [4:0] LAST_FALL = 5'h10;
   localparam logic [4:0] TRACK_RISE = 5'h0D;
   localparam logic [4:0] SAR_STEPS = 5'h08;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   // position of the code msb within the host shift register
   localparam int CODE_MSB_POS = 11;
   localparam int CODE_LSB_POS = 4;
   // ==========================================================
   // reset and idle levels
   localparam logic CS_IDLE = 1'b1;
   localparam logic SCLK_IDLE = 1'b1;
   localparam logic LINE_PULL = 1'b1;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   // ==========================================================
   // timing, host clock 100 MHz
   localparam int CLK_NS = 10;
   localparam int ACQ_MIN_NS = 350;
   localparam int HALF_NS = 40;
   localparam logic [5:0] ACQ_MIN_CYC =
      6'((ACQ_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] HALF_CYC = 6'(HALF_NS / CLK_NS);
   localparam logic [5:0] QUIET_MAX = 6'h3F;
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_LOW = 3'b010,
      ST_HIGH = 3'b011,
      ST_DONE = 3'b100
   } sarf_host_state_t;
endpackage

//--- core/sarf_link_if.sv
// link between the host serial master and the converter device
`timescale 1ns/1ps
interface sarf_link_if;
   logic sclk;
   logic cs_n;
   logic serial_result_d;
   logic serial_result_oe;
   logic serial_result_line;
   // released line floats up through the pull on the board
   assign serial_result_line = serial_result_oe ? serial_result_d
      : sarf_pkg::LINE_PULL;
   modport host_mp (
      output sclk,
      output cs_n,
      input serial_result_line
   );
   modport dev_mp (
      input sclk,
      input cs_n,
      output serial_result_d,
      output serial_result_oe
   );
endinterface

//--- core/sarf_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sarf_sync (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;
   logic next_stage1;
   logic next_sync;

   always_comb begin
      next_stage1 = async_in;
      next_sync = stage1;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         stage1 <= sarf_pkg::LINE_PULL;
         sync_out <= sarf_pkg::LINE_PULL;
      end else begin
         stage1 <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule

//--- core/sarf_host.sv
// host serial master: makes the shift clock and reads one frame
`timescale 1ns/1ps
module sarf_host (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   sarf_link_if.host_mp link,
   output logic [7:0] result_out,
   output logic result_valid_out,
   output logic busy_out
);
   sarf_pkg::sarf_host_state_t state;
   sarf_pkg::sarf_host_state_t next_state;
   logic [5:0] half_cnt;
   logic [5:0] next_half_cnt;
   logic [4:0] fall_n;
   logic [4:0] next_fall_n;
   logic [5:0] quiet;
   logic [5:0] next_quiet;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [7:0] next_result;
   logic next_valid;
   logic sclk;
   logic next_sclk;
   logic cs_n;
   logic next_cs_n;
   logic sd_sync;
   logic half_end;

   sarf_sync u_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in(link.serial_result_line),
      .sync_out(sd_sync)
   );

   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign busy_out = (state != sarf_pkg::ST_IDLE);
   assign half_end = (half_cnt == sarf_pkg::HALF_CYC - 6'h01);

   // ==========================================================
   // frame sequencer
   always_comb begin
      next_state = state;
      next_half_cnt = half_cnt + 6'h01;
      next_fall_n = fall_n;
      next_shreg = shreg;
      next_result = result_out;
      next_valid = 1'b0;
      next_sclk = sclk;
      next_cs_n = cs_n;
      next_quiet = (quiet == sarf_pkg::QUIET_MAX) ? quiet
         : quiet + 6'h01;
      case (state)
         sarf_pkg::ST_IDLE: begin
            next_half_cnt = 6'h00;
            // acquisition window runs from the 13th rise
            if (start_in && quiet >= sarf_pkg::ACQ_MIN_CYC) begin
               next_cs_n = 1'b0;
               next_fall_n = 5'h00;
               next_state = sarf_pkg::ST_SETUP;
            end
         end
         sarf_pkg::ST_SETUP, sarf_pkg::ST_HIGH: begin
            if (half_end) begin
               // a falling edge always follows the frame start
               next_sclk = 1'b0;
               next_half_cnt = 6'h00;
               next_fall_n = fall_n + 5'h01;
               // bit launched on the previous fall is taken here
               next_shreg = {shreg[14:0], sd_sync};
               next_state = sarf_pkg::ST_LOW;
            end
         end
         sarf_pkg::ST_LOW: begin
            if (half_end) begin
               next_sclk = 1'b1;
               next_half_cnt = 6'h00;
               if (fall_n == sarf_pkg::TRACK_RISE) begin
                  next_quiet = 6'h00;
               end
               // sixteen cycles give the whole word
               if (fall_n == sarf_pkg::LAST_FALL) begin
                  next_cs_n = sarf_pkg::CS_IDLE;
                  next_state = sarf_pkg::ST_DONE;
               end else begin
                  next_state = sarf_pkg::ST_HIGH;
               end
            end
         end
         sarf_pkg::ST_DONE: begin
            // first capture is the possible extra zero
            next_result = shreg[sarf_pkg::CODE_MSB_POS:
               sarf_pkg::CODE_LSB_POS];
            next_valid = 1'b1;
            next_state = sarf_pkg::ST_IDLE;
         end
         default: begin
            next_state = sarf_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= sarf_pkg::ST_IDLE;
         half_cnt <= 6'h00;
         fall_n <= 5'h00;
         quiet <= sarf_pkg::QUIET_MAX;
         shreg <= sarf_pkg::SHIFT_RESET;
         result_out <= sarf_pkg::CODE_RESET;
         result_valid_out <= 1'b0;
         sclk <= sarf_pkg::SCLK_IDLE;
         cs_n <= sarf_pkg::CS_IDLE;
      end else begin
         state <= next_state;
         half_cnt <= next_half_cnt;
         fall_n <= next_fall_n;
         quiet <= next_quiet;
         shreg <= next_shreg;
         result_out <= next_result;
         result_valid_out <= next_valid;
         sclk <= next_sclk;
         cs_n <= next_cs_n;
      end
   end
endmodule

//--- core/sarf_device.sv
// converter device end: sample, step the approximation, shift out
//
// Overview of operation
// - frame select fall starts conversion and transfer
// - shift clock edges counted from frame start
// - frame start enables output, samples, holds
// - shift clock alone paces conversion and output
// - back to tracking on 13th rising edge
// - host waits 350 ns before next start
// - output released after 16th fall or select rise
// - host keeps quiet time between conversions
// - sixteen clock cycles read one result
// - bits launched and captured on falling edges
// - three zeros, eight bits msb first, four zeros
// - early select fall gives a fourth zero
// - twenty cycle frames for top throughput; the host clocks sixteen cycles, then waits out the quiet time
// - padding keeps a falling edge at frame start
// - shorter frames allowed when timing holds
// - straight binary code, step is supply over 256
`timescale 1ns/1ps
module sarf_device (
   input wire logic reset_in,
   sarf_link_if.dev_mp link,
   input wire logic [7:0] sample_code_in,
   output logic tracking_out,
   output logic [7:0] held_code_out,
   output logic [7:0] approx_code_out,
   output logic [4:0] fall_count_out,
   output logic frame_done_out
);
   // ==========================================================
   // frame reset
   // the frame select line is the only reset the link has; it
   // clears the edge counts, approximation and data bit while high (the held code keeps its value), so no clock edge is
   // needed between frames
   logic frame_idle;
   logic [4:0] fall_cnt;
   logic [4:0] next_fall_cnt;
   logic [4:0] rise_cnt;
   logic [4:0] next_rise_cnt;
   logic [7:0] held;
   logic [7:0] next_held;
   logic [7:0] sar;
   logic [7:0] next_sar;
   logic [7:0] trial;
   logic [2:0] trial_bit;
   logic [15:0] word;
   logic sd;
   logic next_sd;

   assign frame_idle = reset_in | link.cs_n;

   // ==========================================================
   // sample and hold
   // sample_code_in is the quantised input: code changes at half
   // a step, one step being the supply over 256, straight binary
   always_comb begin
      next_held = sample_code_in;
   end

   // the capture edge is the select fall itself, which is the
   // sampling instant; it never waits for a shift clock edge
   always_ff @(negedge link.cs_n or posedge reset_in) begin
      if (reset_in) begin
         held <= sarf_pkg::CODE_RESET;
      end else begin
         held <= next_held;
      end
   end

   assign held_code_out = held;

   // ==========================================================
   // rising edge numbering, track and hold
   always_comb begin
      next_rise_cnt = rise_cnt;
      if (rise_cnt != sarf_pkg::CNT_MAX) begin
         next_rise_cnt = rise_cnt + 5'h01;
      end
   end

   always_ff @(posedge link.sclk or posedge frame_idle) begin
      if (frame_idle) begin
         rise_cnt <= 5'h00;
      end else begin
         rise_cnt <= next_rise_cnt;
      end
   end

   // tracking while idle; holding from frame start to 13th rise
   assign tracking_out = link.cs_n
      | (rise_cnt >= sarf_pkg::TRACK_RISE);

   // ==========================================================
   // falling edge numbering and approximation steps
   // each of the first eight falling edges decides one code bit,
   // msb first, so the bit is ready before it is shifted out
   always_comb begin
      next_fall_cnt = fall_cnt;
      if (fall_cnt != sarf_pkg::CNT_MAX) begin
         next_fall_cnt = fall_cnt + 5'h01;
      end
      trial_bit = 3'(sarf_pkg::SAR_STEPS - 5'h01 - fall_cnt);
      trial = sar;
      trial[trial_bit] = 1'b1;
      next_sar = sar;
      if (fall_cnt < sarf_pkg::SAR_STEPS) begin
         // comparator: keep the trial bit while not above input
         if (trial <= held) begin
            next_sar = trial;
         end
      end
   end

   always_ff @(negedge link.sclk or posedge frame_idle) begin
      if (frame_idle) begin
         fall_cnt <= 5'h00;
         sar <= sarf_pkg::CODE_RESET;
      end else begin
         fall_cnt <= next_fall_cnt;
         sar <= next_sar;
      end
   end

   assign approx_code_out = sar;
   assign fall_count_out = fall_cnt;
   assign frame_done_out = (fall_cnt >= sarf_pkg::LAST_FALL);

   // ==========================================================
   // output shifter
   // the word is built from the settled approximation; bit k is
   // driven after falling edge k, bit 0 from the select fall on,
   // which a host clocking before its first rise sees as a fourth
   // leading zero
   always_comb begin
      word = {4'h0, next_sar, 4'h0};
      next_sd = 1'b0;
      if (next_fall_cnt < sarf_pkg::LAST_FALL) begin
         next_sd = word[4'(sarf_pkg::LAST_FALL - 5'h01
            - next_fall_cnt)];
      end
   end

   always_ff @(negedge link.sclk or posedge frame_idle) begin
      if (frame_idle) begin
         sd <= 1'b0;
      end else begin
         sd <= next_sd;
      end
   end

   assign link.serial_result_d = sd;

   // ==========================================================
   // output enable
   // driven from select fall to the 16th fall, released at once
   // when select rises early; a truncated word is simply cut
   assign link.serial_result_oe = ~frame_idle
      & (fall_cnt < sarf_pkg::LAST_FALL);

   // the host paces frames
   // nothing here depends on frame spacing beyond the select reset
endmodule

//--- testbench/sarf_assertions.sv
// concurrent checks on the link between host and converter device
`timescale 1ns/1ps
module sarf_assertions (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_result_oe,
   input wire logic serial_result_line
);
   // ==========================================================
   // edge counters, sampled in the host clock domain
   logic sclk_q;
   logic [4:0] fall_cnt;
   logic [4:0] rise_cnt;
   logic [5:0] quiet;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sclk_q <= 1'b1;
         fall_cnt <= 5'h00;
         rise_cnt <= 5'h00;
         quiet <= sarf_pkg::QUIET_MAX;
      end else begin
         sclk_q <= sclk;
         fall_cnt <= cs_n ? 5'h00 : fall_cnt + 5'(sclk_q & ~sclk);
         rise_cnt <= cs_n ? 5'h00 : rise_cnt + 5'(~sclk_q & sclk);
         // both ends of the gap are seen one sample late, so the count
         // is one less than the gap on the wire, as the host's count is
         if (!cs_n && !sclk_q && sclk &&
             rise_cnt == sarf_pkg::TRACK_RISE - 5'h01)
            quiet <= 6'h00;
         else if (quiet != sarf_pkg::QUIET_MAX)
            quiet <= quiet + 6'h01;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   a_start_drive:
      assert property ($fell(cs_n) |-> serial_result_oe && !serial_result_line)
      else $error("line not driven low at frame start");
   a_idle_release:
      assert property (cs_n |-> !serial_result_oe && sclk)
      else $error("line driven or clock moving while idle");
   a_frame_drive:
      assert property (!cs_n && fall_cnt < 5'h0F |-> serial_result_oe)
      else $error("line released inside frame");
   a_last_release:
      assert property (fall_cnt == sarf_pkg::LAST_FALL |-> !serial_result_oe)
      else $error("line still driven after last fall");
   a_bit_hold:
      assert property (!cs_n && $stable(cs_n) && !$fell(sclk)
         |-> $stable(serial_result_line))
      else $error("data changed away from a falling edge");
   a_zero_bits:
      assert property ($fell(sclk) && !cs_n && (fall_cnt < 5'h03 ||
         (fall_cnt > 5'h0A && fall_cnt < 5'h0F)) |-> !serial_result_line)
      else $error("padding bit not zero");
   a_full_frame:
      assert property ($rose(cs_n) |-> fall_cnt == sarf_pkg::LAST_FALL)
      else $error("frame closed without sixteen falls");
   a_quiet_time:
      assert property ($fell(cs_n) |-> quiet >= sarf_pkg::ACQ_MIN_CYC)
      else $error("frame started inside acquisition time");
   a_setup_high:
      assert property ($fell(cs_n) |-> sclk [*4] ##1 !sclk)
      else $error("clock setup after frame start wrong");
   a_half_period:
      assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
      else $error("clock low phase wrong");
endmodule

//--- testbench/tb.sv
// self-checking bench: host and converter device joined by the link
`timescale 1ns/1ps
module tb;
   logic clk_in = 1'b0;
   logic reset_in;
   logic start;
   logic [7:0] sample_code;
   logic [7:0] result_out;
   logic result_valid_out;
   logic busy_out;
   logic tracking;
   logic [7:0] held_code;
   logic [7:0] approx_code;
   logic [4:0] fall_count;
   logic frame_done;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [7:0] codes [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h80};
   always #5 clk_in = ~clk_in;
   // ==========================================================
   // the two ends and the checker
   sarf_link_if u_sarf_link_if ();
   sarf_host u_sarf_host (.clk_in(clk_in), .reset_in(reset_in),
      .start_in(start), .link(u_sarf_link_if.host_mp),
      .result_out(result_out), .result_valid_out(result_valid_out),
      .busy_out(busy_out));
   sarf_device u_sarf_device (.reset_in(reset_in),
      .link(u_sarf_link_if.dev_mp), .sample_code_in(sample_code),
      .tracking_out(tracking), .held_code_out(held_code),
      .approx_code_out(approx_code), .fall_count_out(fall_count),
      .frame_done_out(frame_done));
   sarf_assertions u_sarf_assertions (.clk_in(clk_in), .reset_in(reset_in),
      .sclk(u_sarf_link_if.sclk), .cs_n(u_sarf_link_if.cs_n),
      .serial_result_oe(u_sarf_link_if.serial_result_oe),
      .serial_result_line(u_sarf_link_if.serial_result_line));
   // ==========================================================
   // tasks
   task automatic check(input string name, input logic [15:0] seen,
         input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one conversion; poke raises start again while busy, which is ignored
   task automatic read_word(input logic [7:0] code, input logic poke);
      int n;
      logic [14:0] word;
      logic sclk_q;
      logic [4:0] fc;
      word = 15'h0000;
      sclk_q = 1'b1;
      sample_code = code;
      start = 1'b1;
      for (n = 0; n < 100 && busy_out !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      start = 1'b0;
      for (n = 0; n < 200 && result_valid_out !== 1'b1; ) begin
         @(posedge clk_in);
         #1;
         n++;
         if (poke) start = (n == 50);
         fc = fall_count;
         if (u_sarf_link_if.cs_n === 1'b0) begin
            check("held", 16'(held_code), 16'(code));
            if (fc >= 5'h08) check("approx", 16'(approx_code), 16'(code));
            if (fc <= 5'h0C) check("track", 16'(tracking), 16'h0000);
            if (fc >= 5'h0E) check("track", 16'(tracking), 16'h0001);
            check("done", 16'(frame_done), 16'(fc >= 5'h10));
            if (sclk_q === 1'b1 && u_sarf_link_if.sclk === 1'b0 &&
                u_sarf_link_if.serial_result_oe === 1'b1)
               word = {word[13:0], u_sarf_link_if.serial_result_line};
         end
         sclk_q = u_sarf_link_if.sclk;
      end
      check("latency", 16'(n), 16'h0081);
      check("result", 16'(result_out), 16'(code));
      check("word", 16'(word), {4'h0, code, 4'h0});
      if (poke) begin
         @(posedge clk_in);
         #1;
         check("busy", 16'(busy_out), 16'h0000);
      end
   endtask
   // ==========================================================
   // sequence
   initial begin
      reset_in = 1'b1;
      start = 1'b0;
      sample_code = 8'h00;
      repeat (5) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      check("res_rst", 16'(result_out), 16'(sarf_pkg::CODE_RESET));
      check("held_rst", 16'(held_code), 16'(sarf_pkg::CODE_RESET));
      // back to back frames, so the quiet time is met by the host alone
      foreach (codes[i]) read_word(codes[i], i == 2);
      start = 1'b1;
      repeat (60) @(posedge clk_in);
      #1;
      start = 1'b0;
      reset_in = 1'b1;
      repeat (5) @(posedge clk_in);
      #1;
      check("rst_cs", 16'(u_sarf_link_if.cs_n), 16'h0001);
      check("rst_oe", 16'(u_sarf_link_if.serial_result_oe), 16'h0000);
      check("rst_busy", 16'(busy_out), 16'h0000);
      check("rst_cnt", 16'(fall_count), 16'h0000);
      reset_in = 1'b0;
      read_word(8'h3C, 1'b0);
      stop_test();
   end
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end
endmodule
